// *** rtl/tas_regs.svh ***
`ifndef TAS_REGS_SVH
`define TAS_REGS_SVH
// How it works
// - Comparator mode: alert goes active when temperature exceeds setpoint.
// - Comparator mode: alert stays active until temperature drops below hysteresis.
// - Interrupt mode: exceeding setpoint sets alert; any register read clears it.
// - Interrupt mode: later falling below hysteresis sets alert again until a read.
// - Interrupt mode: alert never clears itself; only a bus read or shutdown entry clears it.
// - Entering shutdown in interrupt mode forces alert inactive.
// - Entering shutdown in comparator mode keeps alert as it was.
// - Alert polarity from config bit; default active low; open-drain pin.
// - Upper four address bits are fixed at 1001.
// - Address acknowledged only when low three bits match address-select inputs.
// - Shutdown bit halts conversions; temperature value stops updating.
// - In shutdown the bus still works and registers stay readable and writable.
// - Temperature moves alert only after the programmed run of equal outcomes, at most six.
// - Receiver pulls data low during the ninth clock's high phase.
// - Data changes only while clock is low, except start and stop.
// - Device is slave only; master makes every clock and transfer.
// - Bytes go MSB first: start, address byte with direction, data bytes.
// - Both lines high means the bus is idle.
// - Bus clock from 0 up to 400 kHz is accepted.
// - Fault filter codes 00,01,10,11 give 1,2,4,6 conversions; default 1.
// - Config bit 1: zero comparator mode, one interrupt mode.
// - Config bit 0: zero normal operation, one shutdown.
// - Config bit 2: zero active low, one active high.
`define TAS_ADDR_PREFIX  4'h9
`define TAS_PTR_TEMP     2'h0
`define TAS_PTR_CONFIG   2'h1
`define TAS_PTR_HYST     2'h2
`define TAS_PTR_SETP     2'h3
`define TAS_CFG_SHDN     0
`define TAS_CFG_MODE     1
`define TAS_CFG_POL      2
`define TAS_CFG_FQ_LO    3
`define TAS_CFG_FQ_HI    4
`define TAS_CFG_RST      8'h00
`define TAS_SETP_RST     9'h0a0
`define TAS_HYST_RST     9'h096
`define TAS_TEMP_RST     9'h000
`define TAS_FQ_MAX       3'h6
`define TAS_SCL_MAX_KHZ  400
`define TAS_SCL_LOW_NS   1250
`endif

// *** rtl/tas_pkg.sv ***
package tas_pkg;
  // Bus engine states, Gray along address, ack, data
  typedef enum logic [2:0] {
    TAS_IDLE = 3'h0,
    TAS_RX   = 3'h1,
    TAS_SACK = 3'h3,
    TAS_TX   = 3'h2,
    TAS_MACK = 3'h6
  } tas_state_e;
  // One finished conversion from the converter side
  typedef struct packed {
    logic       done;
    logic [8:0] temp;
  } tas_conv_s;
  // Configuration view exported to the outside
  typedef struct packed {
    logic [1:0] fault_queue;
    logic       alert_polarity_bit;
    logic       alert_mode_select;
    logic       shutdown;
  } tas_cfg_s;
endpackage : tas_pkg

// *** rtl/tas_top.sv ***
`timescale 1ns/1ps
`include "tas_regs.svh"
module tas_top (
  input  wire logic              mclk_in,         // System clock, 100 MHz
  input  wire logic              rst_b_in,        // Synchronous reset, low
  input  wire logic              conv_clk_in,     // Converter clock domain
  input  wire tas_pkg::tas_conv_s conv_in,        // Conversion result strobe
  input  wire logic              scl_in,          // Bus clock pin
  input  wire logic              sda_in,          // Bus data pin level
  output logic                   sda_drv_out,     // Data pin drive value
  output logic                   sda_oe_b_out,    // Data pin enable, low drives
  input  wire logic [2:0]        addr_select_in,  // addr_select_bit2..0 pins
  input  wire logic              alert_pin_in,    // Alert wire level, unused
  output logic                   alert_drv_out,   // Alert pin drive value
  output logic                   alert_oe_b_out,  // Alert pin enable, low drives
  output logic [8:0]             temp_out,        // Latest temperature
  output tas_pkg::tas_cfg_s      cfg_out          // Configuration bits
);
  // ---------------- Converter domain ----------------
  logic       conv_rst_m, conv_rst_b;
  logic       shdn_m, shdn_c;
  logic       conv_tgl;
  logic [8:0] conv_hold;
  logic       shutdown;

  // Reset into converter domain through two flops
  always_ff @(posedge conv_clk_in) begin
    conv_rst_m <= rst_b_in;
    conv_rst_b <= conv_rst_m;
  end

  // Shutdown level crosses with two flops
  always_ff @(posedge conv_clk_in) begin
    if (!conv_rst_b) begin
      shdn_m <= 1'b1;
      shdn_c <= 1'b1;
    end else begin
      shdn_m <= shutdown;
      shdn_c <= shdn_m;
    end
  end

  // Results held stable; a toggle announces each one
  always_ff @(posedge conv_clk_in) begin
    if (!conv_rst_b) begin
      conv_tgl  <= 1'b0;
      conv_hold <= `TAS_TEMP_RST;
    end else if (conv_in.done && !shdn_c) begin
      conv_tgl  <= ~conv_tgl;
      conv_hold <= conv_in.temp;
    end
  end

  // ---------------- System domain ----------------
  logic [2:0] tgl_s;
  logic       new_temp;
  logic [8:0] temp;

  // Toggle synchroniser; hold word is stable long before toggle lands
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      tgl_s <= 3'h0;
    end else begin
      tgl_s <= {tgl_s[1:0], conv_tgl};
    end
  end
  assign new_temp = tgl_s[2] ^ tgl_s[1];

  // Temperature register
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      temp <= `TAS_TEMP_RST;
    end else if (new_temp) begin
      temp <= conv_hold;
    end
  end

  // Bus and address pins pass two flops, a third gives edges
  logic [2:0] scl_s, sda_s, asel_m, asel_s;
  logic       scl_rise, scl_fall, bus_start, bus_stop;
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      scl_s  <= 3'h7;
      sda_s  <= 3'h7;
      asel_m <= 3'h0;
      asel_s <= 3'h0;
    end else begin
      scl_s  <= {scl_s[1:0], scl_in};
      sda_s  <= {sda_s[1:0], sda_in};
      asel_m <= addr_select_in;
      asel_s <= asel_m;
    end
  end
  assign scl_rise  = scl_s[1] & ~scl_s[2];
  assign scl_fall  = ~scl_s[1] & scl_s[2];
  assign bus_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  assign bus_stop  = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  // ---------------- Registers ----------------
  logic [7:0] config_r;
  logic [8:0] setpoint, hysteresis_threshold;
  logic [1:0] pointer;
  logic [7:0] msb_stage;
  logic       wr_cfg, wr_ptr, wr_word;
  logic [7:0] wr_byte;

  assign shutdown = config_r[`TAS_CFG_SHDN];

  // Pointer register
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      pointer <= `TAS_PTR_TEMP;
    end else if (wr_ptr) begin
      pointer <= wr_byte[1:0];
    end
  end

  // Configuration register, upper bits forced zero
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      config_r <= `TAS_CFG_RST;
    end else if (wr_cfg) begin
      config_r <= {3'h0, wr_byte[4:0]};
    end
  end

  // First byte of a 16-bit write waits for the second
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      msb_stage <= 8'h00;
    end else if (rx_done && (byte_idx == 2'h2)) begin
      msb_stage <= wr_byte;
    end
  end

  // Setpoint and hysteresis, written also in shutdown
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      setpoint             <= `TAS_SETP_RST;
      hysteresis_threshold <= `TAS_HYST_RST;
    end else if (wr_word) begin
      if (pointer == `TAS_PTR_SETP) begin
        setpoint <= {msb_stage, wr_byte[7]};
      end
      if (pointer == `TAS_PTR_HYST) begin
        hysteresis_threshold <= {msb_stage, wr_byte[7]};
      end
    end
  end

  // ---------------- Bus engine ----------------
  tas_pkg::tas_state_e state;
  logic [7:0] sr;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic       rd_dir, nack, rd_clear, sda_oe_b;
  logic [8:0] rd_word;
  logic [7:0] tx_byte;
  logic       rx_done, addr_hit;

  // Read data source; temperature is read-only
  always_comb begin
    case (pointer)
      `TAS_PTR_TEMP:   rd_word = temp;
      `TAS_PTR_HYST:   rd_word = hysteresis_threshold;
      `TAS_PTR_SETP:   rd_word = setpoint;
      default:         rd_word = {config_r, 1'b0};
    endcase
    if (pointer == `TAS_PTR_CONFIG) begin
      tx_byte = config_r;
    end else if (state == tas_pkg::TAS_MACK && byte_idx[0]) begin
      // In the master ack slot byte_idx already counts the first data byte
      tx_byte = {rd_word[0], 7'h00};
    end else begin
      tx_byte = rd_word[8:1];
    end
  end

  assign rx_done  = (state == tas_pkg::TAS_RX) && scl_fall && (bit_cnt == 4'h8);
  assign addr_hit = (sr[7:4] == `TAS_ADDR_PREFIX)
                    && (sr[3:1] == asel_s);
  // Write strobes for data bytes in a write access
  assign wr_byte = sr;
  assign wr_ptr  = rx_done && (byte_idx == 2'h1);
  assign wr_cfg  = rx_done && (byte_idx == 2'h2) && (pointer == `TAS_PTR_CONFIG);
  assign wr_word = rx_done && (byte_idx == 2'h3) && (pointer != `TAS_PTR_CONFIG)
                   && (pointer != `TAS_PTR_TEMP);

  // Slave-only engine: every edge comes from the master
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      state    <= tas_pkg::TAS_IDLE;
      bit_cnt  <= 4'h0;
      byte_idx <= 2'h0;
      rd_dir   <= 1'b0;
      nack     <= 1'b0;
      rd_clear <= 1'b0;
      sr       <= 8'h00;
      sda_oe_b <= 1'b1;
    end else begin
      rd_clear <= 1'b0;
      if (bus_start) begin
        state    <= tas_pkg::TAS_RX;
        bit_cnt  <= 4'h0;
        byte_idx <= 2'h0;
        sda_oe_b <= 1'b1;
      end else if (bus_stop) begin
        state    <= tas_pkg::TAS_IDLE;
        sda_oe_b <= 1'b1;
      end else begin
        case (state)
          tas_pkg::TAS_IDLE: begin
            sda_oe_b <= 1'b1;
          end
          tas_pkg::TAS_RX: begin
            if (scl_rise) begin
              sr      <= {sr[6:0], sda_s[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (byte_idx == 2'h0 && !addr_hit) begin
                state <= tas_pkg::TAS_IDLE;
              end else begin
                state    <= tas_pkg::TAS_SACK;
                sda_oe_b <= 1'b0;
                if (byte_idx == 2'h0) begin
                  rd_dir <= sr[0];
                end
                if (byte_idx != 2'h3) begin
                  byte_idx <= byte_idx + 2'h1;
                end
              end
            end
          end
          tas_pkg::TAS_SACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rd_dir) begin
                state    <= tas_pkg::TAS_TX;
                byte_idx <= 2'h0;
                sr       <= {tx_byte[6:0], 1'b0};
                sda_oe_b <= tx_byte[7];
                rd_clear <= 1'b1;
              end else begin
                state    <= tas_pkg::TAS_RX;
                sda_oe_b <= 1'b1;
              end
            end
          end
          tas_pkg::TAS_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                state    <= tas_pkg::TAS_MACK;
                sda_oe_b <= 1'b1;
                byte_idx <= byte_idx + 2'h1;
              end else begin
                sda_oe_b <= sr[7];
                sr       <= {sr[6:0], 1'b0};
              end
            end
          end
          tas_pkg::TAS_MACK: begin
            if (scl_rise) begin
              nack <= sda_s[1];
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (nack) begin
                state <= tas_pkg::TAS_IDLE;
              end else begin
                state    <= tas_pkg::TAS_TX;
                sr       <= {tx_byte[6:0], 1'b0};
                sda_oe_b <= tx_byte[7];
              end
            end
          end
          default: begin
            state    <= tas_pkg::TAS_IDLE;
            sda_oe_b <= 1'b1;
          end
        endcase
      end
    end
  end

  // ---------------- Alert logic ----------------
  logic [2:0] q_depth, over_cnt, under_cnt, next_over, next_under;
  logic       above, below, trip_hot, trip_cold;
  logic       alert_act, expect_hot, shdn_d, eval_now;

  // Fault queue depth decode
  always_comb begin
    case (config_r[`TAS_CFG_FQ_HI:`TAS_CFG_FQ_LO])
      2'h0:    q_depth = 3'h1;
      2'h1:    q_depth = 3'h2;
      2'h2:    q_depth = 3'h4;
      default: q_depth = `TAS_FQ_MAX;
    endcase
  end

  // Signed compares on each new conversion
  assign above = $signed(temp) > $signed(setpoint);
  assign below = $signed(temp) < $signed(hysteresis_threshold);

  // Run counts saturate at the largest depth
  always_comb begin
    next_over  = 3'h0;
    next_under = 3'h0;
    if (above) begin
      next_over = (over_cnt == `TAS_FQ_MAX) ? over_cnt : over_cnt + 3'h1;
    end
    if (below) begin
      next_under = (under_cnt == `TAS_FQ_MAX) ? under_cnt : under_cnt + 3'h1;
    end
  end
  assign trip_hot  = eval_now && above && (next_over >= q_depth);
  assign trip_cold = eval_now && below && (next_under >= q_depth);

  // Counters act a cycle after temp lands, so compares see the new value
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      eval_now  <= 1'b0;
      over_cnt  <= 3'h0;
      under_cnt <= 3'h0;
    end else begin
      eval_now <= new_temp;
      if (eval_now) begin
        over_cnt  <= next_over;
        under_cnt <= next_under;
      end
    end
  end

  // Previous shutdown level, to spot entry
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      shdn_d <= 1'b0;
    end else begin
      shdn_d <= shutdown;
    end
  end

  // Alert state; a trip in the clearing cycle wins
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      alert_act  <= 1'b0;
      expect_hot <= 1'b1;
    end else if (!config_r[`TAS_CFG_MODE]) begin
      expect_hot <= 1'b1;
      if (trip_hot) begin
        alert_act <= 1'b1;
      end else if (trip_cold) begin
        alert_act <= 1'b0;
      end
      // Shutdown entry leaves the level alone
    end else begin
      if (expect_hot && trip_hot) begin
        alert_act  <= 1'b1;
        expect_hot <= 1'b0;
      end else if (!expect_hot && trip_cold) begin
        alert_act  <= 1'b1;
        expect_hot <= 1'b1;
      end else if (rd_clear) begin
        alert_act <= 1'b0;
      end else if (shutdown && !shdn_d) begin
        alert_act <= 1'b0;
      end
    end
  end

  // ---------------- Registered outputs ----------------
  // Open drain: pin pulled low when active-low alert is on
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      alert_oe_b_out <= 1'b1;
      alert_drv_out  <= 1'b0;
      sda_oe_b_out   <= 1'b1;
      sda_drv_out    <= 1'b0;
      temp_out       <= `TAS_TEMP_RST;
      cfg_out        <= '0;
    end else begin
      alert_oe_b_out <= ~(alert_act ^ config_r[`TAS_CFG_POL]);
      alert_drv_out  <= 1'b0;
      sda_oe_b_out   <= sda_oe_b;
      sda_drv_out    <= 1'b0;
      temp_out       <= temp;
      cfg_out        <= config_r[4:0];
    end
  end
endmodule : tas_top

// *** sim/tas_assertions.sv ***
`timescale 1ns/1ps
module tas_assertions (
  input  wire logic              mclk_in,        // System clock
  input  wire logic              rst_b_in,       // Sync reset, low
  input  wire logic              scl_in,         // Bus clock pin
  input  wire logic              sda_drv_out,    // Data drive value
  input  wire logic              sda_oe_b_out,   // Data enable, low drives
  input  wire logic              alert_drv_out,  // Alert drive value
  input  wire logic              alert_oe_b_out, // Alert enable, low drives
  input  wire logic [8:0]        temp_out,       // Latest temperature
  input  wire tas_pkg::tas_cfg_s cfg_out         // Configuration bits
);
  // Alert is active when the wire sits at the polarity level
  wire alert_act = (alert_oe_b_out == cfg_out.alert_polarity_bit);
  // Shutdown entered while interrupt mode is selected
  sequence s_int_shdn;
    $rose(cfg_out.shutdown) && cfg_out.alert_mode_select;
  endsequence
  sequence s_alert_idle;
    !alert_act;
  endsequence
  // Open drain: only the enable ever moves
  chk_open_drain: assert property (
    @(posedge mclk_in) !sda_drv_out && !alert_drv_out)
    else $error("drive value not low");
  chk_reset_release: assert property (
    @(posedge mclk_in) !rst_b_in |=> sda_oe_b_out && alert_oe_b_out)
    else $error("pin driven in reset");
  chk_reset_cfg: assert property (
    @(posedge mclk_in) !rst_b_in |=> cfg_out == 5'h00 && temp_out == 9'h000)
    else $error("reset value wrong");
  // Device answers a few cycles after the clock fall, never while high
  chk_sda_scl_low: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    $changed(sda_oe_b_out) |-> !scl_in && !$past(scl_in, 2))
    else $error("data changed with clock high");
  chk_int_shdn_clr: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in) s_int_shdn |-> ##[1:4] s_alert_idle)
    else $error("alert kept on shutdown entry");
  // Three settled cycles keep a fresh config write out of the window
  chk_cmp_shdn_hold: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    !cfg_out.alert_mode_select && cfg_out.shutdown && $past(cfg_out, 3) == cfg_out
    |-> $stable(alert_oe_b_out))
    else $error("alert moved in shutdown");
  chk_temp_frozen: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    cfg_out.shutdown && $past(cfg_out.shutdown, 40) |-> $stable(temp_out))
    else $error("temperature moved in shutdown");
  // A read clears only just after a clock fall, so clock is low then
  chk_int_no_selfclr: assert property (
    @(posedge mclk_in) disable iff (!rst_b_in)
    cfg_out.alert_mode_select && $past(cfg_out, 3) == cfg_out
    && $past(alert_act) && !alert_act |-> !scl_in)
    else $error("interrupt alert cleared itself");
endmodule : tas_assertions

bind tas_top tas_assertions tas_assertions_inst (
  .mclk_in(mclk_in), .rst_b_in(rst_b_in), .scl_in(scl_in),
  .sda_drv_out(sda_drv_out), .sda_oe_b_out(sda_oe_b_out),
  .alert_drv_out(alert_drv_out), .alert_oe_b_out(alert_oe_b_out),
  .temp_out(temp_out), .cfg_out(cfg_out));

// *** sim/tas_host.sv ***
`timescale 1ns/1ps
module tas_host (
  input  wire logic mclk_in, // Paces the bus
  input  wire logic sda_in,  // Resolved data wire
  output logic      scl_out, // Bus clock, 1 releases
  output logic      sda_out  // Data, 1 releases
);
  localparam int HALF = 125; // Shortest legal half period
  // Idle: both lines released
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : wt
  // Only the master frames a transfer
  task automatic start_c();
    sda_out <= 1'b0;
    wt(HALF);
    scl_out <= 1'b0;
    wt(1);
  endtask : start_c
  task automatic stop_c();
    sda_out <= 1'b0;
    wt(HALF);
    scl_out <= 1'b1;
    wt(HALF);
    sda_out <= 1'b1;
    wt(HALF);
  endtask : stop_c
  // Data moves only in the low half, sampled at the end of the high
  task automatic bit_c(input logic b, output logic s);
    wt(4);
    sda_out <= b;
    wt(HALF);
    scl_out <= 1'b1;
    wt(HALF);
    s = sda_in;
    scl_out <= 1'b0;
  endtask : bit_c
  task automatic byte_c(input logic [7:0] d, input logic a,
                        output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_c(d[i], r[i]);
    bit_c(a, k);
  endtask : byte_c
endmodule : tas_host

// *** sim/tas_top_tb.sv ***
`timescale 1ns/1ps
module tas_top_tb;
  localparam logic [6:0] DEV = {4'h9, 3'h5};
  logic               mclk, cclk, rst_b, scl, h_sda, sda_oe_b, sda_drv;
  logic               al_oe_b, al_drv, sda_w, al_w;
  logic [8:0]         temp;
  logic [2:0]         asel;
  tas_pkg::tas_conv_s conv;
  tas_pkg::tas_cfg_s  cfg;
  int                 err_total, samples_checked;
  // Pull-ups on both open-drain wires
  assign sda_w = h_sda & (sda_oe_b ? 1'b1 : sda_drv);
  assign al_w  = al_oe_b ? 1'b1 : al_drv;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Converter clock, phase unrelated to the system clock
  initial begin
    cclk = 1'b0;
    #13;
    forever #40 cclk = ~cclk;
  end
  tas_top tas_top_inst (
    .mclk_in(mclk), .rst_b_in(rst_b), .conv_clk_in(cclk), .conv_in(conv),
    .scl_in(scl), .sda_in(sda_w), .sda_drv_out(sda_drv), .sda_oe_b_out(sda_oe_b),
    .addr_select_in(asel), .alert_pin_in(al_w), .alert_drv_out(al_drv),
    .alert_oe_b_out(al_oe_b), .temp_out(temp), .cfg_out(cfg));
  tas_host tas_host_inst (.mclk_in(mclk), .sda_in(sda_w), .scl_out(scl), .sda_out(h_sda));
  task automatic chk(input string nm, input logic [15:0] seen, want);
    samples_checked++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic close_out();
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic al(input logic a);
    chk("alert", {15'h0, al_w === cfg.alert_polarity_bit}, {15'h0, a});
  endtask : al
  // Pointer, then n of value's bytes, high first
  task automatic wr(input logic [7:0] p, input logic [15:0] v, input int n);
    logic [7:0] r;
    logic       k;
    tas_host_inst.start_c();
    tas_host_inst.byte_c({DEV, 1'b0}, 1'b1, r, k);
    chk("addr ack", {15'h0, k}, 16'h0000);
    tas_host_inst.byte_c(p, 1'b1, r, k);
    if (n > 0) tas_host_inst.byte_c(v[15:8], 1'b1, r, k);
    if (n > 1) tas_host_inst.byte_c(v[7:0], 1'b1, r, k);
    chk("data ack", {15'h0, k}, 16'h0000);
    tas_host_inst.stop_c();
  endtask : wr
  // Last byte gets a master refusal to end the read
  task automatic rd(input int n, output logic [15:0] v);
    logic k;
    v = 16'h0000;
    tas_host_inst.start_c();
    tas_host_inst.byte_c({DEV, 1'b1}, 1'b1, v[15:8], k);
    tas_host_inst.byte_c(8'hff, n == 1, v[15:8], k);
    if (n > 1) tas_host_inst.byte_c(8'hff, 1'b1, v[7:0], k);
    tas_host_inst.stop_c();
  endtask : rd
  task automatic cv(input logic [8:0] t);
    @(posedge cclk);
    conv <= '{1'b1, t};
    @(posedge cclk);
    conv.done <= 1'b0;
    repeat (30) @(posedge mclk);
  endtask : cv
  // Step code {read, temperature, expected alert}
  task automatic step(input logic [10:0] s);
    logic [15:0] v;
    if (s[10]) rd(1, v);
    else cv(s[9:1]);
    al(s[0]);
  endtask : step
  task automatic t_addr();
    logic [7:0] r;
    logic       k;
    logic [6:0] bad [2];
    bad = '{{4'h9, 3'h4}, {4'h8, 3'h5}};
    foreach (bad[i]) begin
      tas_host_inst.start_c();
      tas_host_inst.byte_c({bad[i], 1'b0}, 1'b1, r, k);
      tas_host_inst.stop_c();
      chk("foreign addr", {15'h0, k}, 16'h0001);
    end
  endtask : t_addr
  // Negative reading, trip, hysteresis band, release, trip again
  task automatic t_cmp();
    logic [10:0] s [5];
    s = '{11'h39c, 11'h143, 11'h12f, 11'h12a, 11'h143};
    foreach (s[i]) step(s[i]);
  endtask : t_cmp
  task automatic t_shdn();
    logic [15:0] v;
    wr(8'h01, 16'h0100, 1);
    al(1'b1);
    chk("cfg", {11'h0, cfg}, 16'h0001);
    cv(9'h0b0);
    chk("temp", {7'h0, temp}, 16'h00a1);
    wr(8'h03, 16'h5800, 2);
    rd(2, v);
    chk("setpoint", v, 16'h5800);
    wr(8'h01, 16'h0400, 1);
    al(1'b1);
    cv(9'h095);
    al(1'b0);
  endtask : t_shdn
  // Hot event, read, cold event, band, read, hot, then shutdown
  task automatic t_int();
    logic [10:0] s [6];
    s = '{11'h163, 11'h400, 11'h12b, 11'h12f, 11'h400, 11'h163};
    wr(8'h01, 16'h0200, 1);
    chk("cfg", {11'h0, cfg}, 16'h0002);
    foreach (s[i]) step(s[i]);
    wr(8'h01, 16'h0300, 1);
    al(1'b0);
  endtask : t_int
  // Alert moves only on the last conversion of the run
  task automatic t_fault();
    int dep [4];
    dep = '{1, 2, 4, 6};
    for (int c = 1; c < 4; c++) begin
      wr(8'h01, {3'h0, c[1:0], 11'h000}, 1);
      repeat (6) cv(9'h095);
      al(1'b0);
      repeat (dep[c] - 1) step(11'h162);
      step(11'h163);
    end
  endtask : t_fault
  // Reset spans eight converter cycles so both domains see it
  initial begin
    rst_b = 1'b0;
    conv = '0;
    asel = 3'h5;
    err_total = 0;
    samples_checked = 0;
    repeat (8) @(posedge cclk);
    @(posedge mclk);
    rst_b <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("cfg reset", {11'h0, cfg}, 16'h0000);
    al(1'b0);
    t_addr();
    t_cmp();
    t_shdn();
    t_int();
    t_fault();
    close_out();
  end
  // Watchdog: run needs about 86k cycles
  initial begin
    repeat (99000) @(posedge mclk);
    err_total++;
    close_out();
  end
endmodule : tas_top_tb
